// [hw/tirq_pkg.sv]
package tirq_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] TIRQ_RX_STATUS_ADDR = 12'h000;
  localparam logic [11:0] TIRQ_TX_UNMASK_ADDR = 12'h004;
  localparam logic [11:0] TIRQ_RX_UNMASK_ADDR = 12'h008;
  localparam logic [11:0] TIRQ_TX_STATUS_ADDR = 12'h00C;
  localparam logic [11:0] TIRQ_COUNT_ADDR = 12'h010;
  localparam logic [11:0] TIRQ_CONTROL_ADDR = 12'h014;
  localparam logic [11:0] TIRQ_SNAP8_ADDR = 12'h018;
  localparam logic [11:0] TIRQ_SNAP32_ADDR = 12'h01C;
  // ****************************************
  // field positions of the receive status, the more-pending bit and the fifo reset control bit
  // ****************************************
  localparam int TIRQ_BIT_RX_COUNT = 7;
  localparam int TIRQ_BIT_SHORT_OK = 6;
  localparam int TIRQ_BIT_LONG_OK = 5;
  localparam int TIRQ_BIT_OVERRUN = 4;
  localparam int TIRQ_BIT_BYTE_AVAIL = 3;
  localparam int TIRQ_BIT_DELIM = 2;
  localparam int TIRQ_BIT_BUSY = 1;
  localparam int TIRQ_BIT_ANT_LOCK = 0;
  localparam int TIRQ_BIT_MORE = 5;
  localparam int TIRQ_BIT_FIFO_RESET = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] TIRQ_RX_STATUS_RST = 8'h04;
  localparam logic [7:0] TIRQ_TX_STATUS_RST = 8'h21;
  localparam logic [7:0] TIRQ_UNMASK_RST = 8'h00;
  localparam logic [15:0] TIRQ_LIMIT_RST = 16'h0000;
  localparam logic [31:0] TIRQ_ZERO_WORD = 32'h0000_0000;
endpackage : tirq_pkg

// [hw/tirq_w1c_bit.sv]
`timescale 1ns/100ps
// one sticky status bit: set wins over write-one clear
module tirq_w1c_bit
  import tirq_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic set_i, // hardware event
  input wire logic clr_i, // software write of one
  output logic flag_o // sticky flag
);
  typedef struct packed {
    logic flag;
  } tirq_bit_t;
  tirq_bit_t st_q, st_d;

  // set has priority so an event is not lost
  always_comb begin
    st_d = st_q;
    if (clr_i) begin
      st_d.flag = 1'b0; // R1
    end
    if (set_i) begin
      st_d.flag = 1'b1; // R22
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{flag: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag;

  AST_SET_WINS: assert property (@(posedge pclk) // R22
    disable iff (!presetn) set_i |=> flag_o)
    else $error("set lost against clear");
  AST_W0_KEEP: assert property (@(posedge pclk) // R2
    disable iff (!presetn) (!set_i && !clr_i) |=> flag_o == $past(flag_o))
    else $error("flag moved without cause");
endmodule : tirq_w1c_bit

// [hw/tirq_count_match.sv]
`timescale 1ns/100ps
// receive byte counter with limit compare and snapshot on check events
module tirq_count_match
  import tirq_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic fifo_reset_i, // fifo reset, clears count
  input wire logic byte_i, // one byte written to fifo
  input wire logic [15:0] limit_i, // programmed limit
  input wire logic snap8_i, // short check good
  input wire logic snap32_i, // long check good
  output logic [15:0] count_o, // current count
  output logic [15:0] snap8_o, // count at short check good
  output logic [15:0] snap32_o, // count at long check good
  output logic reached_o // one-cycle pulse at limit
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] s8;
    logic [15:0] s32;
    logic hit;
  } tirq_cnt_t;
  tirq_cnt_t st_q, st_d;

  // counting continues past the limit; only the fifo reset stops it
  always_comb begin
    st_d = st_q;
    st_d.hit = 1'b0;
    if (fifo_reset_i) begin
      st_d.cnt = TIRQ_LIMIT_RST; // R5
    end else if (byte_i) begin
      st_d.cnt = st_q.cnt + 16'h0001;
      st_d.hit = (st_q.cnt + 16'h0001) == limit_i; // R4
    end
    if (snap8_i) begin
      st_d.s8 = st_q.cnt; // R6
    end
    if (snap32_i) begin
      st_d.s32 = st_q.cnt; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_o = st_q.cnt;
  assign snap8_o = st_q.s8;
  assign snap32_o = st_q.s32;
  assign reached_o = st_q.hit;

  AST_SNAP8: assert property (@(posedge pclk) // R6
    disable iff (!presetn) snap8_i |=> snap8_o == $past(count_o))
    else $error("short check count not latched");
  AST_KEEP_COUNT: assert property (@(posedge pclk) // R5
    disable iff (!presetn) (reached_o && !fifo_reset_i && byte_i)
    |=> count_o == $past(count_o) + 16'h0001)
    else $error("counting stopped at limit");
endmodule : tirq_count_match

// [hw/tirq_rx_irq.sv]
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
// ****************************************
// receive interrupt status and unmask block
// ****************************************
// Behaviour
// R1 - writing one to a receive status bit clears it
// R2 - writing zero leaves a status bit unchanged
// R3 - masked bits still set but raise no interrupt
// R4 - bit 7 sets when receive byte count reaches the limit
// R5 - reaching the limit does not stop counting; fifo reset does
// R6 - bit 6 sets on short check good, count latched
// R7 - bit 5 sets on long check good, count latched
// R8 - bit 4 sets on receive fifo overrun
// R9 - bit 3 sets while fifo holds a byte
// R10 - bit 2 sets when start delimiter found
// R11 - receive status resets to zero except bit 2 at one
// R12 - bit 1 sets while channel busy is one
// R13 - bit 0 sets from antenna diversity stop indication
// R14 - antenna lock means diversity switching has ceased
// R15 - first unmask bits enable first status bits
// R16 - second unmask bits enable receive status bits
// R17 - first unmask layout: busy change down to tx byte needed
// R18 - second unmask layout: rx count down to antenna lock
// R19 - both unmask registers reset to zero
// R20 - more pending reflects third register only
// R21 - interrupt while any status bit and its unmask are set
// R22 - set wins over a same-cycle clear
module tirq_rx_irq
  import tirq_pkg::*;
(
  input wire logic pclk, // clock, 25 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic rx_byte_written, // byte entered rx fifo
  input wire logic short_check_ok, // short crc good pulse
  input wire logic long_check_ok, // long crc good pulse
  input wire logic rx_fifo_overrun, // fifo overrun pulse
  input wire logic rx_byte_available, // fifo not empty level
  input wire logic start_delimiter_found, // delimiter pulse
  input wire logic channel_busy, // cca busy level
  input wire logic antenna_stop, // diversity stop indication
  input wire logic [7:0] tx_event, // first register set events
  input wire logic [7:0] third_irq_pending, // third register bits
  output logic rx_fifo_reset, // fifo reset control
  output logic antenna_locked, // diversity has ceased
  output logic irq // processor interrupt, high
);
  import tirq_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] tx_unmask;
    logic [7:0] rx_unmask;
    logic [15:0] limit;
    logic fifo_reset;
    logic [31:0] rdata;
    logic irq;
  } tirq_state_t;
  tirq_state_t st_q, st_d;

  logic [7:0] rx_status;
  logic [7:0] tx_status;
  logic [7:0] rx_set;
  logic [7:0] tx_set;
  logic [7:0] rx_clr;
  logic [7:0] tx_clr;
  logic [15:0] count;
  logic [15:0] snap8;
  logic [15:0] snap32;
  logic count_hit;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // apb answers with zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      TIRQ_RX_STATUS_ADDR, TIRQ_TX_UNMASK_ADDR, TIRQ_RX_UNMASK_ADDR,
      TIRQ_TX_STATUS_ADDR, TIRQ_COUNT_ADDR, TIRQ_CONTROL_ADDR,
      TIRQ_SNAP8_ADDR, TIRQ_SNAP32_ADDR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // ****************************************
  // receive event sources
  // ****************************************
  always_comb begin
    rx_set = 8'h00;
    rx_set[TIRQ_BIT_RX_COUNT] = count_hit; // R4
    rx_set[TIRQ_BIT_SHORT_OK] = short_check_ok; // R6
    rx_set[TIRQ_BIT_LONG_OK] = long_check_ok; // R7
    rx_set[TIRQ_BIT_OVERRUN] = rx_fifo_overrun; // R8
    rx_set[TIRQ_BIT_BYTE_AVAIL] = rx_byte_available; // R9
    rx_set[TIRQ_BIT_DELIM] = start_delimiter_found; // R10
    rx_set[TIRQ_BIT_BUSY] = channel_busy; // R12
    rx_set[TIRQ_BIT_ANT_LOCK] = antenna_stop; // R13
  end

  // more pending only ever follows the third register
  always_comb begin
    tx_set = tx_event;
    tx_set[TIRQ_BIT_MORE] = |third_irq_pending; // R20
  end

  // write-one clears, zero bits leave flags alone
  assign rx_clr = (wr_en && paddr == TIRQ_RX_STATUS_ADDR) ?
                  pwdata[7:0] : 8'h00; // R1 R2
  assign tx_clr = (wr_en && paddr == TIRQ_TX_STATUS_ADDR) ?
                  pwdata[7:0] : 8'h00; // R1 R2

  // ****************************************
  // status flags, one per bit
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      tirq_w1c_bit #(.RST_VAL(TIRQ_RX_STATUS_RST[gi])) u_rx ( // R11
        .pclk(pclk),
        .presetn(presetn),
        .set_i(rx_set[gi]),
        .clr_i(rx_clr[gi]),
        .flag_o(rx_status[gi])
      );
      tirq_w1c_bit #(.RST_VAL(TIRQ_TX_STATUS_RST[gi])) u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(tx_set[gi]),
        .clr_i(tx_clr[gi]),
        .flag_o(tx_status[gi])
      );
    end
  endgenerate

  // ****************************************
  // byte counter and check snapshots
  // ****************************************
  tirq_count_match u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .fifo_reset_i(st_q.fifo_reset),
    .byte_i(rx_byte_written),
    .limit_i(st_q.limit),
    .snap8_i(short_check_ok),
    .snap32_i(long_check_ok),
    .count_o(count),
    .snap8_o(snap8),
    .snap32_o(snap32),
    .reached_o(count_hit)
  );

  // ****************************************
  // registers, read data and interrupt
  // ****************************************
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      unique case (paddr)
        TIRQ_TX_UNMASK_ADDR: st_d.tx_unmask = pwdata[7:0]; // R15 R17
        TIRQ_RX_UNMASK_ADDR: st_d.rx_unmask = pwdata[7:0]; // R16 R18
        TIRQ_COUNT_ADDR: st_d.limit = pwdata[15:0];
        TIRQ_CONTROL_ADDR: st_d.fifo_reset = pwdata[TIRQ_BIT_FIFO_RESET];
        default: ;
      endcase
    end
    // read data sampled in setup so it is stable during access
    if (rd_en) begin
      unique case (paddr)
        TIRQ_RX_STATUS_ADDR: st_d.rdata = {24'h00_0000, rx_status};
        TIRQ_TX_UNMASK_ADDR: st_d.rdata = {24'h00_0000, st_q.tx_unmask};
        TIRQ_RX_UNMASK_ADDR: st_d.rdata = {24'h00_0000, st_q.rx_unmask};
        TIRQ_TX_STATUS_ADDR: st_d.rdata = {24'h00_0000, tx_status};
        TIRQ_COUNT_ADDR: st_d.rdata = {count, st_q.limit};
        TIRQ_CONTROL_ADDR: st_d.rdata = {31'h0000_0000, st_q.fifo_reset};
        TIRQ_SNAP8_ADDR: st_d.rdata = {16'h0000, snap8};
        TIRQ_SNAP32_ADDR: st_d.rdata = {16'h0000, snap32};
        default: st_d.rdata = TIRQ_ZERO_WORD;
      endcase
    end
    // masked bits stay visible but never reach the core
    st_d.irq = |(rx_status & st_q.rx_unmask) |
               |(tx_status & st_q.tx_unmask); // R3 R21
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{tx_unmask: TIRQ_UNMASK_RST, rx_unmask: TIRQ_UNMASK_RST,
                limit: TIRQ_LIMIT_RST, fifo_reset: 1'b0,
                rdata: TIRQ_ZERO_WORD, irq: 1'b0}; // R19
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign irq = st_q.irq;
  assign rx_fifo_reset = st_q.fifo_reset;
  // lock flag held means switching stopped, pll may track
  assign antenna_locked = rx_status[TIRQ_BIT_ANT_LOCK]; // R14

  // ****************************************
  // checks
  // ****************************************
  // a write to the receive status register, start of every clear
  sequence s_clear_rx;
    wr_en && paddr == TIRQ_RX_STATUS_ADDR;
  endsequence
  // read setup and access steps of one bus transfer
  sequence s_setup_rd;
    psel && !penable && !pwrite;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  AST_IRQ_CAUSE: assert property (@(posedge pclk) // R21
    disable iff (!presetn) (|(rx_status & st_q.rx_unmask)) |=> irq)
    else $error("unmasked receive bit gave no interrupt");
  AST_MASKED_QUIET: assert property (@(posedge pclk) // R3
    disable iff (!presetn)
    (st_q.rx_unmask == 8'h00 && st_q.tx_unmask == 8'h00) |=> !irq)
    else $error("interrupt with all bits masked");
  AST_BUSY_SET: assert property (@(posedge pclk) // R12
    disable iff (!presetn) channel_busy |=> rx_status[TIRQ_BIT_BUSY])
    else $error("busy channel not flagged");
  AST_OVERRUN_SET: assert property (@(posedge pclk) // R8
    disable iff (!presetn) rx_fifo_overrun |=> rx_status[TIRQ_BIT_OVERRUN])
    else $error("overrun not flagged");
  AST_W1C: assert property (@(posedge pclk) // R1
    disable iff (!presetn)
    (s_clear_rx and pwdata[TIRQ_BIT_DELIM] && !start_delimiter_found)
    |=> !rx_status[TIRQ_BIT_DELIM])
    else $error("write one did not clear");
  AST_MORE: assert property (@(posedge pclk) // R20
    disable iff (!presetn)
    (third_irq_pending == 8'h00 ##1 (tx_clr[TIRQ_BIT_MORE] &&
     third_irq_pending == 8'h00)) |=> !tx_status[TIRQ_BIT_MORE])
    else $error("more pending set without third bits");
  AST_COUNT_FLAG: assert property (@(posedge pclk) // R4
    disable iff (!presetn) count_hit |=> rx_status[TIRQ_BIT_RX_COUNT])
    else $error("count reached not flagged");
  AST_UNMASK_WR: assert property (@(posedge pclk) // R16
    disable iff (!presetn) (wr_en && paddr == TIRQ_RX_UNMASK_ADDR)
    |=> st_q.rx_unmask == $past(pwdata[7:0]))
    else $error("unmask write lost");

  // ****************************************
  // register bus checks
  // ****************************************
  // zero wait states: every access phase must complete at once
  AST_READY: assert property (@(posedge pclk)
    disable iff (!presetn) s_access |-> pready)
    else $error("access phase not ready");
  AST_SLVERR: assert property (@(posedge pclk)
    disable iff (!presetn) (s_access and !addr_ok) |-> pslverr)
    else $error("unmapped access not refused");
  AST_SLVERR_IDLE: assert property (@(posedge pclk)
    disable iff (!presetn) !(psel && penable) |-> !pslverr)
    else $error("error raised outside access phase");
  AST_RD_STATUS: assert property (@(posedge pclk) // R1
    disable iff (!presetn) (s_setup_rd and paddr == TIRQ_RX_STATUS_ADDR)
    |=> prdata == {24'h00_0000, $past(rx_status)})
    else $error("status read data wrong");
  AST_RD_UNMAPPED: assert property (@(posedge pclk)
    disable iff (!presetn) (s_setup_rd and !addr_ok) |=> prdata == '0)
    else $error("unmapped read not zero");
  // captured in setup, so the data must not move under the access
  AST_RD_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn) (s_access and !pwrite) |=> $stable(prdata))
    else $error("read data moved during access");
  AST_RD_COUNT: assert property (@(posedge pclk) // R5
    disable iff (!presetn) (s_setup_rd and paddr == TIRQ_COUNT_ADDR)
    |=> prdata == {$past(count), $past(st_q.limit)})
    else $error("count read data wrong");
  AST_WR_REFUSED: assert property (@(posedge pclk)
    disable iff (!presetn) (wr_en && !addr_ok)
    |=> $stable(st_q.rx_unmask) && $stable(st_q.tx_unmask) &&
    $stable(st_q.limit) && $stable(st_q.fifo_reset))
    else $error("unmapped write took effect");
  AST_TX_UNMASK_WR: assert property (@(posedge pclk) // R15
    disable iff (!presetn) (wr_en && paddr == TIRQ_TX_UNMASK_ADDR)
    |=> st_q.tx_unmask == $past(pwdata[7:0]))
    else $error("first unmask write lost");
  AST_RX_UNMASK_KEEP: assert property (@(posedge pclk) // R16
    disable iff (!presetn)
    !(wr_en && paddr == TIRQ_RX_UNMASK_ADDR) |=> $stable(st_q.rx_unmask))
    else $error("unmask moved without a write");
  AST_LIMIT_WR: assert property (@(posedge pclk) // R4
    disable iff (!presetn) (wr_en && paddr == TIRQ_COUNT_ADDR)
    |=> st_q.limit == $past(pwdata[15:0]))
    else $error("limit write lost");
  AST_FIFO_RST_WR: assert property (@(posedge pclk) // R5
    disable iff (!presetn) (wr_en && paddr == TIRQ_CONTROL_ADDR)
    |=> rx_fifo_reset == $past(pwdata[TIRQ_BIT_FIFO_RESET]))
    else $error("fifo reset write lost");

  // ****************************************
  // reset, event and interrupt checks
  // ****************************************
  // reset values at the first edge after release; no disable on purpose
  AST_RST_STATUS: assert property (@(posedge pclk) // R11
    $rose(presetn) |-> rx_status == TIRQ_RX_STATUS_RST)
    else $error("receive status reset value wrong");
  AST_RST_UNMASK: assert property (@(posedge pclk) // R19
    $rose(presetn) |-> st_q.rx_unmask == TIRQ_UNMASK_RST &&
    st_q.tx_unmask == TIRQ_UNMASK_RST && !irq)
    else $error("unmask reset value wrong");
  AST_SHORT_SET: assert property (@(posedge pclk) // R6
    disable iff (!presetn) short_check_ok |=> rx_status[TIRQ_BIT_SHORT_OK])
    else $error("short check not flagged");
  AST_LONG_SET: assert property (@(posedge pclk) // R7
    disable iff (!presetn) long_check_ok |=> rx_status[TIRQ_BIT_LONG_OK])
    else $error("long check not flagged");
  AST_AVAIL_SET: assert property (@(posedge pclk) // R9
    disable iff (!presetn)
    rx_byte_available |=> rx_status[TIRQ_BIT_BYTE_AVAIL])
    else $error("byte available not flagged");
  AST_DELIM_SET: assert property (@(posedge pclk) // R10
    disable iff (!presetn)
    start_delimiter_found |=> rx_status[TIRQ_BIT_DELIM])
    else $error("delimiter not flagged");
  AST_ANT_SET: assert property (@(posedge pclk) // R13
    disable iff (!presetn) antenna_stop |=> rx_status[TIRQ_BIT_ANT_LOCK])
    else $error("antenna stop not flagged");
  // lock only drops by software, so switching stays stopped meanwhile
  AST_LOCK_HOLD: assert property (@(posedge pclk) // R14
    disable iff (!presetn)
    (antenna_locked && !(wr_en && paddr == TIRQ_RX_STATUS_ADDR &&
    pwdata[TIRQ_BIT_ANT_LOCK])) |=> antenna_locked)
    else $error("antenna lock dropped on its own");
  AST_RX_KEEP0: assert property (@(posedge pclk) // R2
    disable iff (!presetn)
    (s_clear_rx and !pwdata[TIRQ_BIT_RX_COUNT] && !count_hit)
    |=> rx_status[TIRQ_BIT_RX_COUNT] == $past(rx_status[TIRQ_BIT_RX_COUNT]))
    else $error("write of zero moved a status bit");
  AST_MORE_SET: assert property (@(posedge pclk) // R20
    disable iff (!presetn) (|third_irq_pending) |=> tx_status[TIRQ_BIT_MORE])
    else $error("third register pending not passed on");
  AST_SNAP32: assert property (@(posedge pclk) // R7
    disable iff (!presetn) long_check_ok |=> snap32 == $past(count))
    else $error("long check count not latched");
  AST_TX_IRQ: assert property (@(posedge pclk) // R15
    disable iff (!presetn) (|(tx_status & st_q.tx_unmask)) |=> irq)
    else $error("unmasked first status bit gave no interrupt");
  AST_IRQ_QUIET: assert property (@(posedge pclk) // R3
    disable iff (!presetn) (!(|(rx_status & st_q.rx_unmask)) &&
    !(|(tx_status & st_q.tx_unmask))) |=> !irq)
    else $error("interrupt with no unmasked bit set");
endmodule : tirq_rx_irq

// [verif/tirq_rx_src.sv]
`timescale 1ns/100ps
// ****************************************
// receive front end model
// ****************************************
// turns one-cycle bench commands into the event strobes of the receiver;
// the command layout follows the receive status bit positions
module tirq_rx_src (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic [7:0] cmd, // event request, status layout
  input wire logic busy_lvl, // requested channel busy level
  input wire logic fifo_reset, // fifo reset from the block
  output logic byte_wr, // byte entered fifo
  output logic s_ok, // short check good pulse
  output logic l_ok, // long check good pulse
  output logic ovr, // overrun pulse
  output logic avail, // fifo holds a byte
  output logic delim, // delimiter pulse
  output logic busy, // channel busy level
  output logic ant // diversity stop pulse
);
  logic [4:0] fill_q;
  // strobes launched just after the edge, like real receive logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {byte_wr, s_ok, l_ok, ovr, delim, busy, ant} <= 7'h00;
      fill_q <= 5'h00;
    end else begin
      s_ok <= cmd[6];
      l_ok <= cmd[5];
      ovr <= cmd[4];
      byte_wr <= cmd[3] & ~fifo_reset;
      delim <= cmd[2];
      busy <= busy_lvl;
      ant <= cmd[0];
      // a held fifo reset empties the fifo and blocks new bytes
      if (fifo_reset) begin
        fill_q <= 5'h00;
      end else if (cmd[3]) begin
        fill_q <= fill_q + 5'h01;
      end
    end
  end
  // no drain path: bytes stay until the fifo is reset
  assign avail = (fill_q != 5'h00);
endmodule : tirq_rx_src

// [verif/test_tirq_rx_irq.sv]
`timescale 1ns/100ps
// ****************************************
// bench for the receive interrupt block
// ****************************************
module test_tirq_rx_irq;
  import tirq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, busy_lvl = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, rx_fifo_reset, antenna_locked, irq;
  logic [7:0] cmd = 8'h00, tx_event = 8'h00, third = 8'h00;
  logic byte_wr, s_ok, l_ok, ovr, avail, delim, busy, ant;
  int fail_count = 0, num_checks = 0;
  int bits[5] = '{6, 5, 4, 2, 0};
  always #20 pclk = ~pclk;
  tirq_rx_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_byte_written(byte_wr), .short_check_ok(s_ok), .long_check_ok(l_ok),
    .rx_fifo_overrun(ovr), .rx_byte_available(avail),
    .start_delimiter_found(delim), .channel_busy(busy), .antenna_stop(ant),
    .tx_event(tx_event), .third_irq_pending(third),
    .rx_fifo_reset(rx_fifo_reset), .antenna_locked(antenna_locked),
    .irq(irq));
  tirq_rx_src u_src (.pclk(pclk), .presetn(presetn), .cmd(cmd),
    .busy_lvl(busy_lvl), .fifo_reset(rx_fifo_reset), .byte_wr(byte_wr),
    .s_ok(s_ok), .l_ok(l_ok), .ovr(ovr), .avail(avail), .delim(delim),
    .busy(busy), .ant(ant));
  // ****************************************
  // tasks
  // ****************************************
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; starts an edge later so psel never toggles twice
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) begin
      fail_count++;
      $display("ERROR %0t no ready", $time);
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // one-cycle event request, then wait until irq has had time to move
  task ev(input logic [7:0] m);
    @(posedge pclk);
    cmd <= m;
    @(posedge pclk);
    cmd <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask : ev
  // event edge, flag edge, irq edge: read only once irq has settled
  task irq_is(input logic exp);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'(exp));
  endtask : irq_is
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0004);
    rdchk(TIRQ_TX_UNMASK_ADDR, 32'h0000_0000);
    rdchk(TIRQ_RX_UNMASK_ADDR, 32'h0000_0000);
    $display("test reset done");
    wr(TIRQ_TX_UNMASK_ADDR, 32'h0000_005A);
    rdchk(TIRQ_TX_UNMASK_ADDR, 32'h0000_005A);
    wr(TIRQ_RX_UNMASK_ADDR, 32'h0000_00A5);
    rdchk(TIRQ_RX_UNMASK_ADDR, 32'h0000_00A5);
    chk(32'(irq), 32'h0000_0001);
    wr(TIRQ_TX_UNMASK_ADDR, 32'h0000_0000);
    wr(TIRQ_RX_UNMASK_ADDR, 32'h0000_0000);
    irq_is(1'b0);
    $display("test unmask done");
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_00FB);
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0004);
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0004);
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0000);
    // each pulse source lands on its own bit only
    for (int i = 0; i < 5; i++) begin
      ev(8'h01 << bits[i]);
      chk(32'(antenna_locked), 32'(bits[i] == 0));
      rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0001 << bits[i]);
      wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0001 << bits[i]);
    end
    busy_lvl <= 1'b1;
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0002);
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0002);
    busy_lvl <= 1'b0;
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0002);
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0000);
    $display("test events done");
    ev(8'h10);
    chk(32'(irq), 32'h0000_0000);
    wr(TIRQ_RX_UNMASK_ADDR, 32'h0000_0010);
    irq_is(1'b1);
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0010);
    irq_is(1'b0);
    wr(TIRQ_RX_UNMASK_ADDR, 32'h0000_0000);
    // rx status pending must not reach the more-pending bit
    wr(TIRQ_TX_UNMASK_ADDR, 32'h0000_0020);
    wr(TIRQ_TX_STATUS_ADDR, 32'h0000_0021);
    ev(8'h10);
    irq_is(1'b0);
    third <= 8'h01;
    irq_is(1'b1);
    third <= 8'h00;
    wr(TIRQ_TX_STATUS_ADDR, 32'h0000_0020);
    wr(TIRQ_TX_UNMASK_ADDR, 32'h0000_0080);
    irq_is(1'b0);
    tx_event <= 8'h80;
    @(posedge pclk);
    tx_event <= 8'h00;
    irq_is(1'b1);
    wr(TIRQ_TX_STATUS_ADDR, 32'h0000_0080);
    wr(TIRQ_RX_STATUS_ADDR, 32'h0000_0010);
    $display("test masking done");
    wr(TIRQ_COUNT_ADDR, 32'h0000_0002);
    ev(8'h08);
    ev(8'h08);
    rdchk(TIRQ_RX_STATUS_ADDR, 32'h0000_0088);
    ev(8'h08);
    rdchk(TIRQ_COUNT_ADDR, 32'h0003_0002);
    ev(8'h40);
    rdchk(TIRQ_SNAP8_ADDR, 32'h0000_0003);
    ev(8'h20);
    rdchk(TIRQ_SNAP32_ADDR, 32'h0000_0003);
    wr(TIRQ_CONTROL_ADDR, 32'h0000_0001);
    rdchk(TIRQ_COUNT_ADDR, 32'h0000_0002);
    chk(32'(rx_fifo_reset), 32'h0000_0001);
    wr(TIRQ_CONTROL_ADDR, 32'h0000_0000);
    // back-to-back bytes: the byte right after the limit still counts
    wr(TIRQ_COUNT_ADDR, 32'h0000_0001);
    @(posedge pclk);
    cmd <= 8'h08;
    repeat (2) @(posedge pclk);
    cmd <= 8'h00;
    repeat (3) @(posedge pclk);
    rdchk(TIRQ_COUNT_ADDR, 32'h0002_0001);
    $display("test count done");
    xfer(1'b0, 12'h020, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    wr(12'h020, 32'h0000_00FF);
    chk(32'(err), 32'h0000_0001);
    rdchk(TIRQ_RX_UNMASK_ADDR, 32'h0000_0000);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : test_tirq_rx_irq
